// ### rtl/timer_cfg.svh
// constants of the sixteen bit timer: register offsets, reset values, codes
// assumes inclusion by the timer module and its testbench only
`ifndef TIMER_CFG_SVH
`define TIMER_CFG_SVH

// register offsets on the plain register port
`define TMR_ADDR_CTRL 3'h0
`define TMR_ADDR_LOW 3'h1
`define TMR_ADDR_HIGH 3'h2
`define TMR_ADDR_GATE 3'h3
`define TMR_ADDR_STAT 3'h4
`define TMR_ADDR_MASK 3'h5

// reset values
`define TMR_CTRL_RESET 8'h00
`define TMR_GATE_RESET 2'h0
`define TMR_IRQ_RESET 2'h0
`define TMR_BYTE_ZERO 8'h00
`define TMR_COUNT_ZERO 16'h0000
`define TMR_COUNT_MAX 16'hFFFF
`define TMR_COUNT_ONE 16'h0001

// clock select codes
`define TMR_CLK_INSTR 2'h0
`define TMR_CLK_SYS 2'h1
`define TMR_CLK_EXT 2'h2

// prescale codes and divider terminal counts
`define TMR_PRE_1 2'h0
`define TMR_PRE_2 2'h1
`define TMR_PRE_4 2'h2
`define TMR_PRE_8 2'h3
`define TMR_PRE_LAST_1 3'h0
`define TMR_PRE_LAST_2 3'h1
`define TMR_PRE_LAST_4 3'h3
`define TMR_PRE_LAST_8 3'h7
`define TMR_PRE_ZERO 3'h0
`define TMR_PRE_STEP 3'h1

// instruction clock is the system clock divided by four
`define TMR_INSTR_LAST 2'h3
`define TMR_INSTR_ZERO 2'h0
`define TMR_INSTR_STEP 2'h1

// field positions of the gate, status and mask registers
`define TMR_GATE_EN_BIT 0
`define TMR_GATE_POL_BIT 1
`define TMR_IRQ_OVF_BIT 0
`define TMR_IRQ_GATE_BIT 1

// synchroniser lanes
`define TMR_SYNC_WIDTH 5
`define TMR_LANE_EXT 0
`define TMR_LANE_XTAL 1
`define TMR_LANE_DIG 2
`define TMR_LANE_GATE 3
`define TMR_LANE_CFG 4

`endif

// ### rtl/timer_pkg.sv
// types shared by the sixteen bit timer
// assumes nothing beyond the constants header
package timer_pkg;

  // layout of the timer_control register, bit 7 first
  typedef struct packed {
    logic [1:0] clock_select;
    logic [1:0] prescale_select;
    logic secondary_osc_enable;
    logic sync_bypass;
    logic wide_access_enable;
    logic run_enable;
  } control_s;

  // gate configuration, bit 1 first
  typedef struct packed {
    logic gate_polarity;
    logic gate_enable;
  } gate_s;

endpackage : timer_pkg

// ### rtl/timer_sixteen_bit_counter.sv
// sixteen bit timer/counter with prescaler, gate, special event clear and irq
// assumes a plain register port on i_sys_clk and raw pins from outside
//
// The register offsets and the address-and-strobe port were chosen for this implementation.
`timescale 1ns/1ps
`include "timer_cfg.svh"

module timer_sixteen_bit_counter (
  input wire logic i_sys_clk,
  input wire logic i_arst_n,
  input wire logic [2:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic i_special_event,
  input wire logic i_external_count_pin,
  input wire logic i_crystal_in_pin,
  input wire logic i_external_digital_clock_pin,
  input wire logic i_gate_pin,
  input wire logic i_secondary_source_config,
  output logic [7:0] o_rdata,
  output logic o_irq,
  output logic o_crystal_out_pin,
  output logic o_osc_enable
);

  // ************************************************
  // reset release and pin synchronisers
  // ************************************************
  logic [1:0] rst_sync_ff;
  logic rst_n;
  logic [`TMR_SYNC_WIDTH-1:0] meta_ff;
  logic [`TMR_SYNC_WIDTH-1:0] pin_ff;
  logic [`TMR_SYNC_WIDTH-1:0] pin_raw;

  // reset asserts at once, releases two edges later
  always_ff @(posedge i_sys_clk or negedge i_arst_n)
  begin
    if (!i_arst_n)
      rst_sync_ff <= 2'h0;
    else
      rst_sync_ff <= {rst_sync_ff[0], 1'b1};
  end
  assign rst_n = rst_sync_ff[1];

  assign pin_raw[`TMR_LANE_EXT] = i_external_count_pin;
  assign pin_raw[`TMR_LANE_XTAL] = i_crystal_in_pin;
  assign pin_raw[`TMR_LANE_DIG] = i_external_digital_clock_pin;
  assign pin_raw[`TMR_LANE_GATE] = i_gate_pin;
  assign pin_raw[`TMR_LANE_CFG] = i_secondary_source_config;

  // two flops per pin; meta_ff is read by pin_ff only
  for (genvar g = 0; g < `TMR_SYNC_WIDTH; g++)
  begin : g_sync
    always_ff @(posedge i_sys_clk or negedge rst_n)
    begin
      if (!rst_n)
      begin
        meta_ff[g] <= 1'b0;
        pin_ff[g] <= 1'b0;
      end
      else
      begin
        meta_ff[g] <= pin_raw[g];
        pin_ff[g] <= meta_ff[g];
      end
    end
  end

  // ************************************************
  // registers
  // ************************************************
  timer_pkg::control_s ctrl_ff;
  timer_pkg::gate_s gate_ff;
  logic [1:0] stat_ff;
  logic [1:0] mask_ff;
  logic [15:0] count_ff;
  logic [7:0] rd_buf_ff;
  logic [7:0] wr_buf_ff;
  logic wr_ctrl;
  logic wr_low;
  logic wr_high;
  logic rd_low;

  assign wr_ctrl = i_wr && (i_addr == `TMR_ADDR_CTRL);
  assign wr_low = i_wr && (i_addr == `TMR_ADDR_LOW);
  assign wr_high = i_wr && (i_addr == `TMR_ADDR_HIGH);
  assign rd_low = i_rd && (i_addr == `TMR_ADDR_LOW);

  // control and gate configuration
  always_ff @(posedge i_sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ctrl_ff <= `TMR_CTRL_RESET;
      gate_ff <= `TMR_GATE_RESET;
      mask_ff <= `TMR_IRQ_RESET;
    end
    else if (i_wr)
    begin
      if (wr_ctrl)
        ctrl_ff <= i_wdata;
      if (i_addr == `TMR_ADDR_GATE)
        gate_ff <= i_wdata[1:0];
      if (i_addr == `TMR_ADDR_MASK)
        mask_ff <= i_wdata[1:0];
    end
  end

  // ************************************************
  // clock source selection
  // ************************************************
  logic [1:0] instr_div_ff;
  logic instr_tick;
  logic ext_src;
  logic ext_prev_ff;
  logic ext_rise;
  logic ext_rise_ff;
  logic ext_tick;
  logic src_tick;

  // free running divide by four for the instruction clock
  always_ff @(posedge i_sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      instr_div_ff <= `TMR_INSTR_ZERO;
    else
      instr_div_ff <= instr_div_ff + `TMR_INSTR_STEP;
  end
  assign instr_tick = (instr_div_ff == `TMR_INSTR_LAST);

  always_comb
  begin
    if (!ctrl_ff.secondary_osc_enable)
      ext_src = pin_ff[`TMR_LANE_EXT];
    else if (pin_ff[`TMR_LANE_CFG])
      ext_src = pin_ff[`TMR_LANE_DIG];
    else
      ext_src = pin_ff[`TMR_LANE_XTAL];
  end

  // rising edge detect after the pin synchronisers
  always_ff @(posedge i_sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ext_prev_ff <= 1'b0;
      ext_rise_ff <= 1'b0;
    end
    else
    begin
      ext_prev_ff <= ext_src;
      ext_rise_ff <= ext_rise;
    end
  end
  assign ext_rise = ext_src && !ext_prev_ff;

  // bypass drops the extra alignment stage; pins stay double flopped
  assign ext_tick = ctrl_ff.sync_bypass ? ext_rise : ext_rise_ff;

  // internal codes; sync_bypass not consulted here
  always_comb
  begin
    unique case (ctrl_ff.clock_select)
      `TMR_CLK_INSTR: src_tick = instr_tick;
      `TMR_CLK_SYS: src_tick = 1'b1;
      `TMR_CLK_EXT: src_tick = ext_tick;
      default: src_tick = 1'b0; // reserved code never counts
    endcase
  end

  // ************************************************
  // gate, prescaler and counter
  // ************************************************
  logic gate_active;
  logic gate_prev_ff;
  logic gate_ok;
  logic [2:0] pre_cnt_ff;
  logic [2:0] pre_last;
  logic pre_in;
  logic inc;
  logic count_wr;

  // terminal count of the prescaler for each code
  function automatic logic [2:0] pre_last_of(input logic [1:0] code);
    unique case (code)
      `TMR_PRE_1: pre_last_of = `TMR_PRE_LAST_1;
      `TMR_PRE_2: pre_last_of = `TMR_PRE_LAST_2;
      `TMR_PRE_4: pre_last_of = `TMR_PRE_LAST_4;
      `TMR_PRE_8: pre_last_of = `TMR_PRE_LAST_8;
    endcase
  endfunction : pre_last_of

  // gate level compared against its polarity
  assign gate_active = (pin_ff[`TMR_LANE_GATE] == gate_ff.gate_polarity);
  assign gate_ok = !gate_ff.gate_enable || gate_active;
  assign count_wr = wr_low || (wr_high && !ctrl_ff.wide_access_enable);

  // only while running and the gate allows
  assign pre_in = ctrl_ff.run_enable && gate_ok && src_tick;
  // count advances once per prescaler wrap
  assign pre_last = pre_last_of(ctrl_ff.prescale_select);
  assign inc = pre_in && (pre_cnt_ff >= pre_last);

  // prescaler is cleared by count writes so a new value starts clean
  always_ff @(posedge i_sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      pre_cnt_ff <= `TMR_PRE_ZERO;
    else if (count_wr || i_special_event || inc)
      pre_cnt_ff <= `TMR_PRE_ZERO;
    else if (pre_in)
      pre_cnt_ff <= pre_cnt_ff + `TMR_PRE_STEP;
  end

  // special event first, then software writes, then counting
  // byte writes; wide mode writes through the buffer
  always_ff @(posedge i_sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      count_ff <= `TMR_COUNT_ZERO;
    else if (i_special_event)
      count_ff <= `TMR_COUNT_ZERO;
    // buffered high byte goes in with the low byte
    else if (wr_low && ctrl_ff.wide_access_enable)
      count_ff <= {wr_buf_ff, i_wdata};
    else if (wr_low)
      count_ff[7:0] <= i_wdata;
    else if (count_wr)
      count_ff[15:8] <= i_wdata;
    else if (inc)
      count_ff <= count_ff + `TMR_COUNT_ONE;
  end

  // high byte buffers for coherent wide access
  always_ff @(posedge i_sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rd_buf_ff <= `TMR_BYTE_ZERO;
      wr_buf_ff <= `TMR_BYTE_ZERO;
    end
    else
    begin
      if (rd_low)
        rd_buf_ff <= count_ff[15:8];
      if (wr_high)
        wr_buf_ff <= i_wdata;
    end
  end

  // ************************************************
  // interrupts and oscillator
  // ************************************************
  logic ovf_evt;
  logic gate_evt;
  logic [1:0] evt;
  logic wr_stat;

  assign ovf_evt = inc && (count_ff == `TMR_COUNT_MAX) && !i_special_event && !count_wr;
  // gate event when an enabled gate closes
  assign gate_evt = gate_ff.gate_enable && gate_prev_ff && !gate_active;
  assign evt[`TMR_IRQ_OVF_BIT] = ovf_evt;
  assign evt[`TMR_IRQ_GATE_BIT] = gate_evt;
  assign wr_stat = i_wr && (i_addr == `TMR_ADDR_STAT);

  always_ff @(posedge i_sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      gate_prev_ff <= 1'b0;
    else
      gate_prev_ff <= gate_active;
  end

  // sticky flags, write one clears, a same cycle event wins
  always_ff @(posedge i_sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      stat_ff <= `TMR_IRQ_RESET;
    else if (wr_stat)
      stat_ff <= (stat_ff & ~i_wdata[1:0]) | evt;
    else
      stat_ff <= stat_ff | evt;
  end

  // mask gates each flag onto the level interrupt
  always_ff @(posedge i_sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      o_irq <= 1'b0;
    else
      o_irq <= |(stat_ff & mask_ff);
  end

  // inverter enabled only with the oscillator, low otherwise
  always_ff @(posedge i_sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      o_osc_enable <= 1'b0;
      o_crystal_out_pin <= 1'b0;
    end
    else
    begin
      o_osc_enable <= ctrl_ff.secondary_osc_enable;
      o_crystal_out_pin <= ctrl_ff.secondary_osc_enable && !pin_ff[`TMR_LANE_XTAL];
    end
  end

  // ************************************************
  // read port, data one cycle after the strobe
  // ************************************************
  always_ff @(posedge i_sys_clk or negedge rst_n)
  begin
    if (!rst_n)
      o_rdata <= `TMR_BYTE_ZERO;
    else if (i_rd)
    begin
      unique case (i_addr)
        `TMR_ADDR_CTRL: o_rdata <= ctrl_ff;
        `TMR_ADDR_LOW: o_rdata <= count_ff[7:0];
        // wide mode returns the high byte caught at the low read
        `TMR_ADDR_HIGH: o_rdata <= ctrl_ff.wide_access_enable ? rd_buf_ff : count_ff[15:8];
        `TMR_ADDR_GATE: o_rdata <= {6'h00, gate_ff};
        `TMR_ADDR_STAT: o_rdata <= {6'h00, stat_ff};
        `TMR_ADDR_MASK: o_rdata <= {6'h00, mask_ff};
        default: o_rdata <= `TMR_BYTE_ZERO; // unmapped reads zero
      endcase
    end
  end

  // ************************************************
  // assertions
  // ************************************************
  a_halt_holds: assert property (
    @(posedge i_sys_clk) disable iff (!rst_n)
    (!ctrl_ff.run_enable && !i_wr && !i_special_event) |=> $stable(count_ff))
    else $error("count moved while halted");

  a_special_clear: assert property (
    @(posedge i_sys_clk) disable iff (!rst_n)
    i_special_event |=> (count_ff == `TMR_COUNT_ZERO))
    else $error("special event did not clear count");

  a_overflow_flag: assert property (
    @(posedge i_sys_clk) disable iff (!rst_n)
    ovf_evt |=> stat_ff[`TMR_IRQ_OVF_BIT] ##1 o_irq == mask_ff[`TMR_IRQ_OVF_BIT])
    else $error("overflow flag or irq wrong");

  a_sys_rate: assert property (
    @(posedge i_sys_clk) disable iff (!rst_n)
    (ctrl_ff.run_enable && ctrl_ff.clock_select == `TMR_CLK_SYS && gate_ok
     && ctrl_ff.prescale_select == `TMR_PRE_1 && !i_wr && !i_special_event)
    |=> count_ff == $past(count_ff) + `TMR_COUNT_ONE)
    else $error("system clock source did not count every cycle");

  a_instr_spacing: assert property (
    @(posedge i_sys_clk) disable iff (!rst_n)
    instr_tick |=> !instr_tick [*3] ##1 instr_tick)
    else $error("instruction clock not one in four");

  a_prescale_two: assert property (
    @(posedge i_sys_clk) disable iff (!rst_n)
    (pre_in && ctrl_ff.prescale_select == `TMR_PRE_2 && pre_cnt_ff == `TMR_PRE_ZERO)
    |-> !inc)
    else $error("divide by two counted on first tick");

  a_gate_blocks: assert property (
    @(posedge i_sys_clk) disable iff (!rst_n)
    (gate_ff.gate_enable && !gate_active) |-> !inc)
    else $error("closed gate let the count advance");

  a_internal_nosync: assert property (
    @(posedge i_sys_clk) disable iff (!rst_n)
    (ctrl_ff.clock_select == `TMR_CLK_INSTR) |-> (src_tick == instr_tick))
    else $error("internal source depends on sync select");

  a_wide_latch: assert property (
    @(posedge i_sys_clk) disable iff (!rst_n)
    (rd_low && ctrl_ff.wide_access_enable) ##1 (i_rd && i_addr == `TMR_ADDR_HIGH)
    |=> o_rdata == $past(count_ff[15:8], 2))
    else $error("wide read lost the latched high byte");

  a_osc_off: assert property (
    @(posedge i_sys_clk) disable iff (!rst_n)
    !ctrl_ff.secondary_osc_enable |=> (!o_osc_enable && !o_crystal_out_pin))
    else $error("oscillator driven while disabled");

endmodule : timer_sixteen_bit_counter

// ### tb/ext_clock_model.sv
// far side model: external count pin, crystal input and digital clock pin
// assumes the bench clock; every source stands still while i_run is low
`timescale 1ns/1ps

module ext_clock_model (
  input wire logic i_sys_clk,
  input wire logic i_run,
  input wire logic i_osc_enable,
  output logic o_count_pin,
  output logic o_crystal,
  output logic o_digital
);
  logic [3:0] phase_ff = 4'h0;

  // ****************************************
  // source generator
  // ****************************************
  // distinct periods (16, 8, 4 cycles) reveal which source gets counted
  always_ff @(posedge i_sys_clk)
  begin
    if (i_run)
      phase_ff <= phase_ff + 4'h1;
    else
      phase_ff <= 4'h0;
  end

  assign o_count_pin = phase_ff[3];
  assign o_digital = phase_ff[1];
  // crystal swings only with its inverter powered
  assign o_crystal = phase_ff[2] & i_osc_enable;
endmodule : ext_clock_model

// ### tb/timer_sixteen_bit_counter_tb.sv
// self-checking bench of the sixteen bit timer: table of clock modes, then
// hand-written reset, wide access, overflow, special event and gate cases
// assumes the design's register map header and no other stimulus source
`timescale 1ns/1ps
`include "timer_cfg.svh"

module timer_sixteen_bit_counter_tb;
  typedef struct packed {
    logic [7:0] ctrl;
    logic cfg;
    logic [7:0] lo;
    logic [7:0] hi;
  } row_s;

  // ctrl, config bit, accepted range of the low byte after 64 cycles
  localparam row_s ROWS [12] = '{
    '{8'h41, 1'b0, 8'h3F, 8'h41}, '{8'h51, 1'b0, 8'h1F, 8'h21},
    '{8'h61, 1'b0, 8'h0F, 8'h11}, '{8'h71, 1'b0, 8'h07, 8'h09},
    '{8'h01, 1'b0, 8'h0F, 8'h11}, '{8'h05, 1'b0, 8'h0F, 8'h11},
    '{8'h81, 1'b0, 8'h03, 8'h05}, '{8'h85, 1'b0, 8'h03, 8'h05},
    '{8'h89, 1'b0, 8'h07, 8'h09}, '{8'h89, 1'b1, 8'h0F, 8'h11},
    '{8'h8D, 1'b1, 8'h0F, 8'h11}, '{8'hC1, 1'b0, 8'h00, 8'h00}};

  logic sys_clk = 1'b0;
  logic arst_n = 1'b0;
  logic [2:0] addr = 3'h0;
  logic [7:0] wdata = 8'h00;
  logic wr_stb = 1'b0;
  logic rd_stb = 1'b0;
  logic special = 1'b0;
  logic gate_pin = 1'b0;
  logic src_cfg = 1'b0;
  logic model_run = 1'b0;
  logic count_pin;
  logic crystal;
  logic digital;
  logic [7:0] rdata;
  logic irq;
  logic xtal_out;
  logic osc_en;
  int num_errors = 0;
  int comparisons = 0;

  // 25 MHz system clock
  always #20 sys_clk = ~sys_clk;

  timer_sixteen_bit_counter u_dut (
    .i_sys_clk(sys_clk), .i_arst_n(arst_n), .i_addr(addr), .i_wdata(wdata),
    .i_wr(wr_stb), .i_rd(rd_stb), .i_special_event(special),
    .i_external_count_pin(count_pin), .i_crystal_in_pin(crystal),
    .i_external_digital_clock_pin(digital), .i_gate_pin(gate_pin),
    .i_secondary_source_config(src_cfg), .o_rdata(rdata), .o_irq(irq),
    .o_crystal_out_pin(xtal_out), .o_osc_enable(osc_en)
  );

  ext_clock_model u_model (
    .i_sys_clk(sys_clk), .i_run(model_run), .i_osc_enable(osc_en),
    .o_count_pin(count_pin), .o_crystal(crystal), .o_digital(digital)
  );

  // ****************************************
  // bus tasks and checks
  // ****************************************
  task automatic complete_run;
    $display("errors %0d, comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : complete_run

  task automatic check(input logic [7:0] got, input logic [7:0] lo, input logic [7:0] hi);
    comparisons++;
    if (!((got === lo) || (got === hi) || ((^got !== 1'bx) && got > lo && got < hi)))
    begin
      num_errors++;
      $display("MISMATCH at %0t: got %h, want %h..%h", $time, got, lo, hi);
    end
  endtask : check

  // one-cycle write strobe, held until the taking edge
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    addr <= a;
    wdata <= d;
    wr_stb <= 1'b1;
    @(posedge sys_clk);
    wr_stb <= 1'b0;
  endtask : wr

  // read data stand from the cycle after the strobe until the next read
  task automatic rc(input logic [2:0] a, input logic [7:0] lo, input logic [7:0] hi);
    @(posedge sys_clk);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge sys_clk);
    rd_stb <= 1'b0;
    #1;
    check(rdata, lo, hi);
  endtask : rc

  // bounded wait for the interrupt level; running out ends the run
  task automatic wait_irq(input logic exp);
    int n;
    n = 0;
    while (irq !== exp && n < 8)
    begin
      @(posedge sys_clk);
      n++;
    end
    check({7'h00, irq}, {7'h00, exp}, {7'h00, exp});
    // a used-up bound is already counted above; stop here
    if (irq !== exp)
      complete_run();
  endtask : wait_irq

  // ****************************************
  // main sequence
  // ****************************************
  initial
  begin
    repeat (2) @(posedge sys_clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge sys_clk);
    rc(`TMR_ADDR_CTRL, 8'h00, 8'h00);
    rc(`TMR_ADDR_STAT, 8'h00, 8'h00);
    rc(`TMR_ADDR_MASK, 8'h00, 8'h00);
    wr(3'h7, 8'hFF);
    rc(3'h7, 8'h00, 8'h00);
    // the clock select field is software's: never the system clock with capture
    foreach (ROWS[i])
    begin
      wr(`TMR_ADDR_CTRL, ROWS[i].ctrl & 8'hFE);
      src_cfg <= ROWS[i].cfg;
      wr(`TMR_ADDR_HIGH, 8'h00);
      wr(`TMR_ADDR_LOW, 8'h00);
      model_run <= 1'b1;
      wr(`TMR_ADDR_CTRL, ROWS[i].ctrl);
      repeat (62) @(posedge sys_clk);
      wr(`TMR_ADDR_CTRL, ROWS[i].ctrl & 8'hFE);
      model_run <= 1'b0;
      rc(`TMR_ADDR_LOW, ROWS[i].lo, ROWS[i].hi);
      rc(`TMR_ADDR_LOW, ROWS[i].lo, ROWS[i].hi);
      rc(`TMR_ADDR_HIGH, 8'h00, 8'h00);
    end
    wr(`TMR_ADDR_CTRL, 8'hFE);
    src_cfg <= 1'b0;
    rc(`TMR_ADDR_CTRL, 8'hFE, 8'hFE);
    check({6'h00, osc_en, xtal_out}, 8'h03, 8'h03);
    wr(`TMR_ADDR_CTRL, 8'h00);
    // oscillator outputs follow the register one edge late
    repeat (2) @(posedge sys_clk);
    #1;
    check({6'h00, osc_en, xtal_out}, 8'h00, 8'h00);
    // wide mode: high byte write goes to the buffer only
    wr(`TMR_ADDR_HIGH, 8'h00);
    wr(`TMR_ADDR_CTRL, 8'h02);
    wr(`TMR_ADDR_HIGH, 8'hAB);
    wr(`TMR_ADDR_CTRL, 8'h00);
    rc(`TMR_ADDR_HIGH, 8'h00, 8'h00);
    wr(`TMR_ADDR_CTRL, 8'h02);
    wr(`TMR_ADDR_LOW, 8'h34);
    wr(`TMR_ADDR_CTRL, 8'h00);
    rc(`TMR_ADDR_HIGH, 8'hAB, 8'hAB);
    wr(`TMR_ADDR_HIGH, 8'h56);
    wr(`TMR_ADDR_CTRL, 8'h02);
    rc(`TMR_ADDR_LOW, 8'h34, 8'h34);
    wr(`TMR_ADDR_CTRL, 8'h00);
    wr(`TMR_ADDR_HIGH, 8'h78);
    wr(`TMR_ADDR_CTRL, 8'h02);
    rc(`TMR_ADDR_HIGH, 8'h56, 8'h56);
    // back to back wide read: low then high in adjacent cycles
    @(posedge sys_clk);
    addr <= `TMR_ADDR_LOW;
    rd_stb <= 1'b1;
    @(posedge sys_clk);
    addr <= `TMR_ADDR_HIGH;
    #1;
    check(rdata, 8'h34, 8'h34);
    @(posedge sys_clk);
    rd_stb <= 1'b0;
    #1;
    check(rdata, 8'h78, 8'h78);
    // overflow from FFFE, first masked then unmasked
    wr(`TMR_ADDR_CTRL, 8'h00);
    wr(`TMR_ADDR_HIGH, 8'hFF);
    wr(`TMR_ADDR_LOW, 8'hFE);
    wr(`TMR_ADDR_CTRL, 8'h41);
    repeat (4) @(posedge sys_clk);
    wr(`TMR_ADDR_CTRL, 8'h40);
    rc(`TMR_ADDR_HIGH, 8'h00, 8'h00);
    rc(`TMR_ADDR_STAT, 8'h01, 8'h01);
    wait_irq(1'b0);
    wr(`TMR_ADDR_MASK, 8'h01);
    wait_irq(1'b1);
    wr(`TMR_ADDR_STAT, 8'h01);
    wait_irq(1'b0);
    rc(`TMR_ADDR_STAT, 8'h00, 8'h00);
    // special event clears a running count; capture use keeps off the system clock
    wr(`TMR_ADDR_HIGH, 8'h12);
    wr(`TMR_ADDR_LOW, 8'h00);
    wr(`TMR_ADDR_CTRL, 8'h01);
    @(posedge sys_clk);
    special <= 1'b1;
    @(posedge sys_clk);
    special <= 1'b0;
    wr(`TMR_ADDR_CTRL, 8'h00);
    rc(`TMR_ADDR_HIGH, 8'h00, 8'h00);
    rc(`TMR_ADDR_LOW, 8'h00, 8'h01);
    // gate armed, pin raised; the flag from arming is cleared before the test
    wr(`TMR_ADDR_GATE, 8'h01);
    gate_pin <= 1'b1;
    wr(`TMR_ADDR_LOW, 8'h00);
    wr(`TMR_ADDR_STAT, 8'h02);
    wr(`TMR_ADDR_MASK, 8'h02);
    wr(`TMR_ADDR_CTRL, 8'h41);
    repeat (16) @(posedge sys_clk);
    rc(`TMR_ADDR_LOW, 8'h00, 8'h00);
    rc(`TMR_ADDR_STAT, 8'h00, 8'h00);
    // open for 16 cycles, then the closing is the event
    @(posedge sys_clk);
    gate_pin <= 1'b0;
    repeat (16) @(posedge sys_clk);
    gate_pin <= 1'b1;
    repeat (8) @(posedge sys_clk);
    wr(`TMR_ADDR_CTRL, 8'h40);
    rc(`TMR_ADDR_LOW, 8'h0E, 8'h14);
    rc(`TMR_ADDR_STAT, 8'h02, 8'h02);
    wait_irq(1'b1);
    wr(`TMR_ADDR_STAT, 8'h02);
    wait_irq(1'b0);
    // inverted polarity: gate open while the pin is high
    wr(`TMR_ADDR_GATE, 8'h03);
    wr(`TMR_ADDR_LOW, 8'h00);
    wr(`TMR_ADDR_CTRL, 8'h41);
    repeat (6) @(posedge sys_clk);
    wr(`TMR_ADDR_CTRL, 8'h40);
    rc(`TMR_ADDR_STAT, 8'h00, 8'h00);
    rc(`TMR_ADDR_LOW, 8'h08, 8'h08);
    // reset in mid-run returns registers and outputs to zero
    wr(`TMR_ADDR_CTRL, 8'h0B);
    repeat (2) @(posedge sys_clk);
    arst_n <= 1'b0;
    repeat (2) @(posedge sys_clk);
    check(rdata, 8'h00, 8'h00);
    check({6'h00, osc_en, irq}, 8'h00, 8'h00);
    arst_n <= 1'b1;
    repeat (3) @(posedge sys_clk);
    rc(`TMR_ADDR_CTRL, 8'h00, 8'h00);
    rc(`TMR_ADDR_GATE, 8'h00, 8'h00);
    rc(`TMR_ADDR_MASK, 8'h00, 8'h00);
    rc(`TMR_ADDR_LOW, 8'h00, 8'h00);
    complete_run();
  end
endmodule : timer_sixteen_bit_counter_tb
